// File: design/asrc_pkg.sv
// Package for the asynchronous SRAM host controller: timing, pin bundles.
// Assumes a 100 MHz core clock; all times but output-drive-to-valid and write cycle minimum are converted to whole cycles.
package asrc_pkg;

   // ------------------------------------------------------------
   // Clock and speed grade
   // ------------------------------------------------------------
   localparam int CLK_PERIOD_PS = 10000;
   localparam int ADDR_W = 20;
   localparam int DATA_W = 16;

   // Times in picoseconds, fast grade then slow grade
   localparam int READ_CYCLE_MIN_PS_F = 10000;
   localparam int READ_CYCLE_MIN_PS_S = 15000;
   localparam int ADDR_TO_VALID_TIME_PS_F = 10000;
   localparam int ADDR_TO_VALID_TIME_PS_S = 15000;
   localparam int OUTDRIVE_TO_VALID_TIME_PS_F = 5000;
   localparam int OUTDRIVE_TO_VALID_TIME_PS_S = 8000;
   localparam int WRITE_CYCLE_MIN_PS_F = 10000;
   localparam int WRITE_CYCLE_MIN_PS_S = 15000;
   localparam int WRITE_PULSE_MIN_PS_F = 7000;
   localparam int WRITE_PULSE_MIN_PS_S = 12000;
   localparam int WDATA_SETUP_TIME_PS_F = 5000;
   localparam int WDATA_SETUP_TIME_PS_S = 8000;
   localparam int STROBE_TO_FLOAT_TIME_PS_F = 5000;
   localparam int STROBE_TO_FLOAT_TIME_PS_S = 8000;
   localparam int WRITE_RECOVERY_PS = 3000;
   // Supply stable wait in microseconds
   localparam int SUPPLY_STABLE_WAIT_US = 100;

   // Rounds a least time up to whole cycles, never below one
   function automatic int asrc_cyc(input int ps);
      int c;
      c = (ps + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
      return (c < 1) ? 1 : c;
   endfunction : asrc_cyc

   localparam int CNT_W = 8;
   // Read count adds a launch cycle and three synchroniser cycles
   localparam logic [CNT_W-1:0] RD_CYC_F = CNT_W'(asrc_cyc(
      (READ_CYCLE_MIN_PS_F > ADDR_TO_VALID_TIME_PS_F) ?
      READ_CYCLE_MIN_PS_F : ADDR_TO_VALID_TIME_PS_F) + 4);
   localparam logic [CNT_W-1:0] RD_CYC_S = CNT_W'(asrc_cyc(
      (READ_CYCLE_MIN_PS_S > ADDR_TO_VALID_TIME_PS_S) ?
      READ_CYCLE_MIN_PS_S : ADDR_TO_VALID_TIME_PS_S) + 4);
   // Write pulse covers pulse minimum and float plus data setup
   localparam logic [CNT_W-1:0] WR_PULSE_F = CNT_W'(asrc_cyc(
      (WRITE_PULSE_MIN_PS_F > STROBE_TO_FLOAT_TIME_PS_F
       + WDATA_SETUP_TIME_PS_F) ? WRITE_PULSE_MIN_PS_F :
      STROBE_TO_FLOAT_TIME_PS_F + WDATA_SETUP_TIME_PS_F));
   localparam logic [CNT_W-1:0] WR_PULSE_S = CNT_W'(asrc_cyc(
      (WRITE_PULSE_MIN_PS_S > STROBE_TO_FLOAT_TIME_PS_S
       + WDATA_SETUP_TIME_PS_S) ? WRITE_PULSE_MIN_PS_S :
      STROBE_TO_FLOAT_TIME_PS_S + WDATA_SETUP_TIME_PS_S));
   localparam logic [CNT_W-1:0] WR_RECOV_CYC = CNT_W'(asrc_cyc(
      WRITE_RECOVERY_PS));
   localparam int POWER_WAIT_CYC_DEF =
      SUPPLY_STABLE_WAIT_US * 1000000 / CLK_PERIOD_PS;

   // ------------------------------------------------------------
   // Pin bundles
   // ------------------------------------------------------------
   typedef struct packed {
      logic [ADDR_W-1:0] addr;
      logic first_select_n;
      logic second_select_high;
      logic outdrive_n;
      logic write_strobe_n;
      logic high_byte_lane_n;
      logic low_byte_lane_n;
      logic sleep_request_n;
   } asrc_ctl_t;

   localparam asrc_ctl_t CTL_IDLE = '{addr: '0, first_select_n: 1'b1,
      second_select_high: 1'b0, outdrive_n: 1'b1, write_strobe_n: 1'b1,
      high_byte_lane_n: 1'b1, low_byte_lane_n: 1'b1,
      sleep_request_n: 1'b1};

   typedef struct packed {
      logic write;
      logic [ADDR_W-1:0] addr;
      logic [1:0] lanes;
      logic [DATA_W-1:0] wdata;
   } asrc_req_t;

   typedef enum logic [4:0] {
      ST_POWER = 5'h01,
      ST_IDLE = 5'h02,
      ST_READ = 5'h04,
      ST_WRITE = 5'h08,
      ST_RECOV = 5'h10
   } asrc_state_t;

endpackage : asrc_pkg

// File: design/asrc_in_sync.sv
// Three-stage synchroniser for the read data and error flag pins.
// Assumes the pins are asynchronous to core_clk.
`timescale 1ns/1ps
module asrc_in_sync
   import asrc_pkg::*;
#(
   parameter int W = 17
)
(
   input wire logic core_clk,
   input wire logic rst,
   input wire logic [W-1:0] pin_i,
   output logic [W-1:0] value_o
);

   logic [W-1:0] s1_q;
   logic [W-1:0] s2_q;
   logic [W-1:0] s3_q;

   // ------------------------------------------------------------
   // Stages; a change counts once stages two and three agree
   // ------------------------------------------------------------
   always_ff @(posedge core_clk or posedge rst)
   begin
      if (rst)
      begin
         s1_q <= '0;
         s2_q <= '0;
         s3_q <= '0;
      end
      else
      begin
         s1_q <= pin_i;
         s2_q <= s1_q;
         s3_q <= s2_q;
      end
   end

   genvar b;
   generate
      for (b = 0; b < W; b++)
      begin : g_bit
         logic hold_q;
         always_ff @(posedge core_clk or posedge rst)
         begin
            if (rst)
               hold_q <= 1'b0;
            else if (s2_q[b] == s3_q[b])
               hold_q <= s3_q[b];
         end
         assign value_o[b] = hold_q;
      end
   endgenerate

endmodule : asrc_in_sync

// File: design/asrc_host.sv
// Host controller driving an asynchronous 1M x 16 SRAM with byte lanes.
// Assumes one request at a time on the user side and a 100 MHz clock.
//
// Summary of operation
// - Hold read address at least the read cycle
// - Write only while strobe, select, lane low
// - Address set before write, held to end; the code sets the address on the same edge that the strobe falls
// - Address kept through terminating edge
// - Write data valid setup before end
// - Lanes, strobe, select held minimum before end
// - Strobe pulse covers float plus setup
// - Sleep request high; strobe high on reads
// - Wait for supply before first access
// - Never sleep while selected
`timescale 1ns/1ps
module asrc_host
   import asrc_pkg::*;
#(
   parameter int POWER_WAIT_CYC = POWER_WAIT_CYC_DEF
)
(
   input wire logic core_clk,
   input wire logic rst,
   input wire logic slow_grade,
   input wire logic req_valid,
   input wire asrc_req_t req,
   output logic req_ready,
   output logic rsp_valid,
   output logic [DATA_W-1:0] rsp_rdata,
   output logic rsp_err,
   output asrc_ctl_t mem_ctl,
   output logic [DATA_W-1:0] mem_dq_o,
   output logic [1:0] mem_dq_oe,
   input wire logic [DATA_W-1:0] mem_dq_i,
   input wire logic mem_err_i
);

   asrc_state_t state_q;
   logic [CNT_W-1:0] cnt_q;
   logic [31:0] pwr_q;
   logic [DATA_W:0] sync_val;
   logic [1:0] lanes_q;

   // ------------------------------------------------------------
   // Pin synchroniser
   // ------------------------------------------------------------
   asrc_in_sync #(.W(DATA_W + 1)) u_sync (
      .core_clk(core_clk),
      .rst(rst),
      .pin_i({mem_err_i, mem_dq_i}),
      .value_o(sync_val)
   );

   // ------------------------------------------------------------
   // Sequencer
   // ------------------------------------------------------------
   always_ff @(posedge core_clk or posedge rst)
   begin
      if (rst)
      begin
         state_q <= ST_POWER;
         cnt_q <= '0;
         req_ready <= 1'b0;
      end
      else
      begin
         case (state_q)
            ST_POWER:
            begin
               if (pwr_q >= 32'(POWER_WAIT_CYC - 1))
               begin
                  state_q <= ST_IDLE;
                  req_ready <= 1'b1;
               end
            end
            ST_IDLE:
            begin
               if (req_valid)
               begin
                  req_ready <= 1'b0;
                  if (req.write)
                  begin
                     state_q <= ST_WRITE;
                     cnt_q <= slow_grade ? WR_PULSE_S : WR_PULSE_F;
                  end
                  else
                  begin
                     state_q <= ST_READ;
                     cnt_q <= slow_grade ? RD_CYC_S : RD_CYC_F;
                  end
               end
            end
            ST_READ:
            begin
               // Extra cycles cover the input synchroniser delay
               if (cnt_q == 8'h00)
               begin
                  state_q <= ST_RECOV;
                  cnt_q <= WR_RECOV_CYC;
               end
               else
                  cnt_q <= cnt_q - 8'h01;
            end
            ST_WRITE:
            begin
               if (cnt_q == 8'h01)
               begin
                  state_q <= ST_RECOV;
                  cnt_q <= WR_RECOV_CYC;
               end
               else
                  cnt_q <= cnt_q - 8'h01;
            end
            ST_RECOV:
            begin
               if (cnt_q <= 8'h01)
               begin
                  state_q <= ST_IDLE;
                  req_ready <= 1'b1;
               end
               else
                  cnt_q <= cnt_q - 8'h01;
            end
            default:
            begin
               state_q <= ST_POWER;
               req_ready <= 1'b0;
            end
         endcase
      end
   end

   // ------------------------------------------------------------
   // Supply wait counter
   // ------------------------------------------------------------
   always_ff @(posedge core_clk or posedge rst)
   begin
      if (rst)
         pwr_q <= '0;
      else if (state_q == ST_POWER)
         pwr_q <= pwr_q + 32'h1;
   end

   // ------------------------------------------------------------
   // Lanes of the access in flight
   // ------------------------------------------------------------
   always_ff @(posedge core_clk or posedge rst)
   begin
      if (rst)
         lanes_q <= 2'h0;
      else if (state_q == ST_IDLE && req_valid)
         lanes_q <= req.lanes;
   end

   // ------------------------------------------------------------
   // Memory pins
   // ------------------------------------------------------------
   always_ff @(posedge core_clk or posedge rst)
   begin
      if (rst)
      begin
         mem_ctl <= CTL_IDLE;
         mem_dq_o <= '0;
         mem_dq_oe <= 2'h0;
      end
      else
      begin
         mem_ctl.sleep_request_n <= 1'b1;
         if (state_q == ST_IDLE && req_valid)
         begin
            mem_ctl.addr <= req.addr;
            mem_ctl.first_select_n <= 1'b0;
            mem_ctl.second_select_high <= 1'b1;
            mem_ctl.high_byte_lane_n <= ~req.lanes[1];
            mem_ctl.low_byte_lane_n <= ~req.lanes[0];
            mem_ctl.outdrive_n <= req.write;
            mem_ctl.write_strobe_n <= ~req.write;
            mem_dq_o <= req.wdata;
            mem_dq_oe <= req.write ? req.lanes : 2'h0;
         end
         else if ((state_q == ST_WRITE && cnt_q == 8'h01) ||
                  (state_q == ST_READ && cnt_q == 8'h00))
         begin
            // Strobe and select rise together; address and data held
            mem_ctl.write_strobe_n <= 1'b1;
            mem_ctl.first_select_n <= 1'b1;
            mem_ctl.second_select_high <= 1'b0;
            mem_ctl.outdrive_n <= 1'b1;
            mem_ctl.high_byte_lane_n <= 1'b1;
            mem_ctl.low_byte_lane_n <= 1'b1;
         end
         else if (state_q == ST_RECOV)
            mem_dq_oe <= 2'h0;
      end
   end

   // ------------------------------------------------------------
   // Read answer
   // ------------------------------------------------------------
   always_ff @(posedge core_clk or posedge rst)
   begin
      if (rst)
      begin
         rsp_valid <= 1'b0;
         rsp_rdata <= '0;
         rsp_err <= 1'b0;
      end
      else
      begin
         rsp_valid <= 1'b0;
         if (state_q == ST_READ && cnt_q == 8'h00)
         begin
            rsp_valid <= 1'b1;
            rsp_rdata[7:0] <= lanes_q[0] ? sync_val[7:0] : 8'h00;
            rsp_rdata[15:8] <= lanes_q[1] ? sync_val[15:8] : 8'h00;
            rsp_err <= sync_val[DATA_W];
         end
      end
   end

endmodule : asrc_host

// File: dv/asrc_host_monitor.sv
// Checker of the SRAM host controller pin sequencing.
// Assumes it is bound into asrc_host.
`timescale 1ns/1ps
module asrc_host_monitor
   import asrc_pkg::*;
#(
   parameter int POWER_WAIT_CYC = 4
)
(
   input wire logic core_clk,
   input wire logic rst,
   input wire logic slow_grade,
   input wire logic req_valid,
   input wire asrc_req_t req,
   input wire logic req_ready,
   input wire logic rsp_valid,
   input wire asrc_ctl_t mem_ctl,
   input wire logic [DATA_W-1:0] mem_dq_o,
   input wire logic [1:0] mem_dq_oe
);
   // ------------------------------------------------------------
   // Helpers and assertions
   // ------------------------------------------------------------
   logic [15:0] up_q;
   logic grade_q;
   wire sel = !mem_ctl.first_select_n && mem_ctl.second_select_high;
   wire [1:0] lane = ~{mem_ctl.high_byte_lane_n, mem_ctl.low_byte_lane_n};
   wire ws = mem_ctl.write_strobe_n;
   wire od = mem_ctl.outdrive_n;
   always_ff @(posedge core_clk or posedge rst)
      if (rst)
         up_q <= '0;
      else if (up_q != 16'hFFFF)
         up_q <= up_q + 16'h1;
   always_ff @(posedge core_clk or posedge rst)
      if (rst)
         grade_q <= 1'b0;
      else if (req_valid && req_ready)
         grade_q <= slow_grade;
   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (rst);
   AST_POWER: assert property (
      req_ready |-> up_q >= 16'(POWER_WAIT_CYC))
      else $error("ready before power wait");
   AST_SLEEP: assert property (
      mem_ctl.sleep_request_n)
      else $error("sleep request asserted");
   AST_SEL: assert property (
      mem_ctl.first_select_n == !mem_ctl.second_select_high)
      else $error("selects disagree");
   AST_RDWR: assert property (
      !od |-> ws && mem_dq_oe == 2'h0)
      else $error("drive during read");
   AST_ADDR: assert property (
      sel && $past(sel) |-> $stable(mem_ctl.addr))
      else $error("address moved while selected");
   AST_WRLANE: assert property (
      !ws |-> sel && mem_dq_oe == lane)
      else $error("write lanes wrong");
   AST_WREND: assert property (
      $rose(ws) |-> mem_ctl.first_select_n && $stable(mem_dq_o)
         ##1 mem_dq_oe == 2'h0)
      else $error("write end wrong");
   AST_WRPULSE: assert property (
      $fell(ws) && grade_q |=> !ws)
      else $error("slow strobe short");
   AST_RDLEN: assert property (
      $fell(od) && grade_q |-> !od [*3])
      else $error("slow read short");
   AST_TAKE: assert property (
      req_valid && req_ready && req.lanes != 2'h0 |=> sel
         && mem_ctl.addr == $past(req.addr) && lane == $past(req.lanes))
      else $error("pins wrong after take");
   COV_WR: cover property ($rose(ws) && grade_q);
   COV_RD: cover property (rsp_valid);
   COV_NOLANE: cover property (req_valid && req_ready && req.lanes == 2'h0);
endmodule : asrc_host_monitor

bind asrc_host asrc_host_monitor #(.POWER_WAIT_CYC(POWER_WAIT_CYC)) u_mon (
   .core_clk(core_clk), .rst(rst), .slow_grade(slow_grade),
   .req_valid(req_valid), .req(req), .req_ready(req_ready),
   .rsp_valid(rsp_valid), .mem_ctl(mem_ctl), .mem_dq_o(mem_dq_o),
   .mem_dq_oe(mem_dq_oe));

// File: dv/asrc_sram_model.sv
// Behavioural 1M x 16 SRAM with byte lanes and a corrected-error flag.
// Assumes split data pins; flags a correction when address bit 3 is set.
`timescale 1ns/1ps
module asrc_sram_model
   import asrc_pkg::*;
#(
   parameter int ACC_NS = 9
)
(
   input wire asrc_ctl_t ctl,
   input wire logic [DATA_W-1:0] dq_o,
   input wire logic [1:0] dq_oe,
   output logic [DATA_W-1:0] dq_i,
   output logic err_o
);
   // ------------------------------------------------------------
   // Storage and pins
   // ------------------------------------------------------------
   logic [DATA_W-1:0] mem [logic [ADDR_W-1:0]];
   logic [DATA_W-1:0] rd, nx, wd, prev;
   logic [DATA_W-1:0] dq_r = 16'h5A3C;
   logic err_r = 1'b0;
   logic en, wl, wh;
   logic [ADDR_W-1:0] wa;
   wire sel = !ctl.first_select_n && ctl.second_select_high;
   wire wr = sel && !ctl.write_strobe_n
      && !(ctl.high_byte_lane_n && ctl.low_byte_lane_n);
   wire rd_on = sel && !ctl.outdrive_n && ctl.write_strobe_n;
   always @*
      if (wr)
      begin
         wa = ctl.addr;
         wl = !ctl.low_byte_lane_n;
         wh = !ctl.high_byte_lane_n;
         wd[7:0] = dq_oe[0] ? dq_o[7:0] : 8'hXX;
         wd[15:8] = dq_oe[1] ? dq_o[15:8] : 8'hXX;
      end
   always @(negedge wr)
   begin
      prev = mem.exists(wa) ? mem[wa] : 16'h0;
      mem[wa] = {wh ? wd[15:8] : prev[15:8],
         wl ? wd[7:0] : prev[7:0]};
   end
   always @*
   begin
      rd = mem.exists(ctl.addr) ? mem[ctl.addr] : 16'h0;
      en = rd_on && !ctl.low_byte_lane_n;
      nx[7:0] = en ? rd[7:0] : ~dq_r[7:0];
      en = rd_on && !ctl.high_byte_lane_n;
      nx[15:8] = en ? rd[15:8] : ~dq_r[15:8];
   end
   always @(nx)
      dq_r <= #(ACC_NS) nx;
   always @(rd_on or ctl.addr or err_r)
      err_r <= #(ACC_NS) rd_on ? ctl.addr[3] : ~err_r;
   assign dq_i[7:0] = dq_oe[0] ? dq_o[7:0] : dq_r[7:0];
   assign dq_i[15:8] = dq_oe[1] ? dq_o[15:8] : dq_r[15:8];
   assign err_o = err_r;
endmodule : asrc_sram_model

// File: dv/testbench.sv
// Self-checking bench: random writes and reads against a shadow memory.
// Assumes asrc_host with a short power wait and the SRAM model.
`timescale 1ns/1ps
module testbench
   import asrc_pkg::*;
;
   // ------------------------------------------------------------
   // Signals, tasks and sequence
   // ------------------------------------------------------------
   localparam int PW = 4;
   logic core_clk, rst, slow_grade, req_valid, req_ready, rsp_valid;
   logic rsp_err, mem_err_i;
   asrc_req_t req;
   asrc_ctl_t mem_ctl;
   logic [DATA_W-1:0] rsp_rdata, mem_dq_o, mem_dq_i;
   logic [1:0] mem_dq_oe, ln;
   logic [ADDR_W-1:0] a;
   logic [DATA_W-1:0] shadow [logic [ADDR_W-1:0]];
   logic [DATA_W:0] exp_q [$];
   logic [DATA_W:0] e;
   logic [31:0] seed = 32'hC1DEA7B8;
   int bad_count = 0;
   int total_checks = 0;
   int cyc = 0;
   asrc_host #(.POWER_WAIT_CYC(PW)) uut (.core_clk(core_clk), .rst(rst),
      .slow_grade(slow_grade), .req_valid(req_valid), .req(req),
      .req_ready(req_ready), .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata),
      .rsp_err(rsp_err), .mem_ctl(mem_ctl), .mem_dq_o(mem_dq_o),
      .mem_dq_oe(mem_dq_oe), .mem_dq_i(mem_dq_i), .mem_err_i(mem_err_i));
   asrc_sram_model u_mem (.ctl(mem_ctl), .dq_o(mem_dq_o),
      .dq_oe(mem_dq_oe), .dq_i(mem_dq_i), .err_o(mem_err_i));
   always #5 core_clk = ~core_clk;
   function automatic logic [31:0] xs(input logic [31:0] s);
      s = s ^ (s << 13);
      s = s ^ (s >> 17);
      return s ^ (s << 5);
   endfunction : xs
   task automatic check(input logic [DATA_W:0] seen,
      input logic [DATA_W:0] ex);
      total_checks++;
      if (seen !== ex)
      begin
         bad_count++;
         $display("wrong value at %0t: saw %h expected %h", $time, seen, ex);
      end
   endtask : check
   task automatic complete_run;
      $display("checks %0d mismatches %0d", total_checks, bad_count);
      if (bad_count == 0 && total_checks > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask : complete_run
   task automatic access(input logic wr, input logic [DATA_W-1:0] d);
      logic [DATA_W-1:0] old;
      int n;
      @(negedge core_clk);
      req_valid = 1'b1;
      req = '{write: wr, addr: a, lanes: ln, wdata: d};
      n = 0;
      do
         @(posedge core_clk);
      while (req_ready !== 1'b1 && ++n < 100);
      check({16'h0, req_ready}, 17'h1);
      @(negedge core_clk);
      req_valid = 1'b0;
      old = shadow.exists(a) ? shadow[a] : 16'h0;
      if (wr)
         shadow[a] = {ln[1] ? d[15:8] : old[15:8],
            ln[0] ? d[7:0] : old[7:0]};
      else
         exp_q.push_back({a[3], ln[1] ? old[15:8] : 8'h0,
            ln[0] ? old[7:0] : 8'h0});
   endtask : access
   always @(negedge core_clk)
      if (rsp_valid === 1'b1)
      begin
         e = (exp_q.size() != 0) ? exp_q.pop_front() : 'x;
         check({rsp_err, rsp_rdata}, e);
      end
   always @(negedge core_clk)
      if (++cyc == 20000)
      begin
         bad_count++;
         complete_run();
      end
   initial
   begin
      core_clk = 1'b0;
      rst = 1'b1;
      slow_grade = 1'b0;
      req_valid = 1'b0;
      req = '0;
      repeat (5) @(posedge core_clk);
      @(negedge core_clk);
      rst = 1'b0;
      repeat (PW - 1)
      begin
         @(negedge core_clk);
         check({16'h0, req_ready}, 17'h0);
      end
      for (int i = 0; i < 120; i++)
      begin
         seed = xs(seed);
         a = {seed[4] ? 16'hFFFF : 16'h0, seed[3:0]};
         ln = seed[8:7];
         if (!seed[6] && ln == 2'h0)
            ln = 2'h3;
         slow_grade = seed[5];
         access(seed[6], seed[31:16]);
      end
      repeat (20) @(negedge core_clk);
      check({16'h0, exp_q.size() == 0}, 17'h1);
      complete_run();
   end
endmodule : testbench
